// ### logic/pipad_pkg.sv
// Package for the pipe address register bank.
// Assumes a single 100 MHz clock and byte-serial register writes.
package pipad_pkg;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [4:0] PIPAD_OFS_P0 = 5'h0A;
  localparam logic [4:0] PIPAD_OFS_P1 = 5'h0B;
  localparam logic [4:0] PIPAD_OFS_P2 = 5'h0C;
  localparam logic [4:0] PIPAD_OFS_P3 = 5'h0D;
  localparam logic [4:0] PIPAD_OFS_P4 = 5'h0E;
  localparam logic [4:0] PIPAD_OFS_P5 = 5'h0F;
  localparam logic [4:0] PIPAD_OFS_TX = 5'h10;
  // ---------------------------------------------------------------
  // Widths and reset values
  // ---------------------------------------------------------------
  localparam int PIPAD_AW = 40;
  localparam int PIPAD_NBYTES = 5;
  localparam logic [39:0] PIPAD_RST_P0 = 40'hE7_E7E7_E7E7;
  localparam logic [39:0] PIPAD_RST_P1 = 40'hC2_C2C2_C2C2;
  localparam logic [7:0] PIPAD_RST_P2 = 8'hC3;
  localparam logic [7:0] PIPAD_RST_P3 = 8'hC4;
  localparam logic [7:0] PIPAD_RST_P4 = 8'hC5;
  localparam logic [7:0] PIPAD_RST_P5 = 8'hC6;
  localparam logic [39:0] PIPAD_RST_TX = 40'hE7_E7E7_E7E7;
  // Address width setting codes: 1 = 3 bytes, 2 = 4 bytes, 3 = 5 bytes
  localparam logic [1:0] PIPAD_AW_3B = 2'h1;
  localparam logic [1:0] PIPAD_AW_4B = 2'h2;
  localparam logic [1:0] PIPAD_AW_5B = 2'h3;
  localparam logic [2:0] PIPAD_PIPE_NONE = 3'h7;
  typedef enum logic [1:0] {
    PIPAD_IDLE = 2'b00,
    PIPAD_WRITE = 2'b01,
    PIPAD_READ = 2'b11
  } pipad_state_e;
endpackage

// ### logic/pipad_match.sv
// Pipe address matcher: compares a received address with pipe addresses.
// Assumes addresses are presented already assembled, LSB in bits 7:0.
module pipad_match (
  input wire logic ref_clk_in, // 100 MHz clock
  input wire logic rst_in, // Sync reset, active high
  input wire logic check_in, // Received address valid, one cycle
  input wire logic [39:0] rx_addr_in, // Received address
  input wire logic [39:0] mask_in, // Bytes in use for this width
  input wire logic [5:0] pipe_en_in, // Pipe enables
  input wire logic [39:0] p0_in, // Pipe 0 address
  input wire logic [39:0] p1_in, // Pipe 1 address
  input wire logic [7:0] p2_in, // Pipe 2 low byte
  input wire logic [7:0] p3_in, // Pipe 3 low byte
  input wire logic [7:0] p4_in, // Pipe 4 low byte
  input wire logic [7:0] p5_in, // Pipe 5 low byte
  input wire logic [39:0] tx_in, // Transmit address
  input wire logic ptx_in, // Primary transmitter role
  output logic hit_out, // Match found, one cycle
  output logic [2:0] pipe_out // Pipe number of match
);
  logic hit_reg, hit_next;
  logic [2:0] pipe_reg, pipe_next;
  logic [39:0] full [6];

  function automatic logic same(input logic [39:0] a, input logic [39:0] b,
                                input logic [39:0] m);
    same = ((a ^ b) & m) == 40'h00_0000_0000;
  endfunction

  always_comb begin
    full[0] = ptx_in ? tx_in : p0_in;
    full[1] = p1_in;
    full[2] = {p1_in[39:8], p2_in};
    full[3] = {p1_in[39:8], p3_in};
    full[4] = {p1_in[39:8], p4_in};
    full[5] = {p1_in[39:8], p5_in};
    hit_next = 1'b0;
    pipe_next = pipad_pkg::PIPAD_PIPE_NONE;
    if (check_in) begin
      for (int i = 5; i >= 0; i--) begin
        if (pipe_en_in[i] && same(rx_addr_in, full[i], mask_in)) begin
          hit_next = 1'b1;
          pipe_next = 3'(i);
        end
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      hit_reg <= 1'b0;
      pipe_reg <= pipad_pkg::PIPAD_PIPE_NONE;
    end else begin
      hit_reg <= hit_next;
      pipe_reg <= pipe_next;
    end
  end

  assign hit_out = hit_reg;
  assign pipe_out = pipe_reg;
endmodule

// ### logic/pipad_regs.sv
// Pipe and transmit address registers, byte-serial access.
// Assumes a register access engine delivers start, byte strobes and stop
// synchronous to ref_clk_in.
module pipad_regs (
  input wire logic ref_clk_in, // 100 MHz clock
  input wire logic rst_in, // Sync reset, active high
  input wire logic start_in, // Access begins, one cycle
  input wire logic write_in, // Access is a write
  input wire logic [4:0] addr_in, // Register offset
  input wire logic byte_in, // Byte strobe, one cycle
  input wire logic [7:0] wdata_in, // Write byte
  input wire logic stop_in, // Access ends, one cycle
  input wire logic [1:0] address_width_setting_in, // Address width code
  input wire logic primary_transmitter_role_in, // Transmitter role
  input wire logic [5:0] pipe_en_in, // Receive pipe enables
  input wire logic check_in, // Received address valid
  input wire logic [39:0] rx_addr_in, // Received address
  output logic [7:0] rdata_out, // Read byte for current position
  output logic [39:0] active_tx_out, // Address used when transmitting
  output logic hit_out, // Packet accepted, one cycle
  output logic [2:0] pipe_out // Pipe number of accepted packet
);
  // -----------------------------------------------------------------
  // State
  // -----------------------------------------------------------------
  pipad_pkg::pipad_state_e st_reg, st_next;
  logic [4:0] sel_reg, sel_next;
  logic [2:0] idx_reg, idx_next;
  logic [39:0] p0_reg, p0_next;
  logic [39:0] p1_reg, p1_next;
  logic [7:0] lo_reg [2:5];
  logic [7:0] lo_next [2:5];
  logic [39:0] tx_reg, tx_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [39:0] atx_reg, atx_next;
  logic [2:0] nbytes;
  logic [39:0] mask;

  function automatic logic [39:0] put_byte(input logic [39:0] v,
                                           input logic [2:0] i,
                                           input logic [7:0] b);
    logic [39:0] r;
    r = v;
    r[i*8 +: 8] = b;
    put_byte = r;
  endfunction

  // Bytes past the register read as zero
  function automatic logic [7:0] get_byte(input logic [39:0] v,
                                          input logic [2:0] i);
    get_byte = 8'h00;
    if (i < 3'(pipad_pkg::PIPAD_NBYTES)) begin
      get_byte = v[i*8 +: 8];
    end
  endfunction

  function automatic logic [7:0] lo_byte(input logic [7:0] v,
                                         input logic [2:0] i);
    lo_byte = (i == 3'h0) ? v : 8'h00;
  endfunction

  // -----------------------------------------------------------------
  // Width decode
  // -----------------------------------------------------------------
  always_comb begin
    unique case (address_width_setting_in)
      pipad_pkg::PIPAD_AW_3B: begin
        nbytes = 3'd3;
        mask = 40'h00_00FF_FFFF;
      end
      pipad_pkg::PIPAD_AW_4B: begin
        nbytes = 3'd4;
        mask = 40'h00_FFFF_FFFF;
      end
      default: begin
        nbytes = 3'(pipad_pkg::PIPAD_NBYTES);
        mask = 40'hFF_FFFF_FFFF;
      end
    endcase
  end

  // -----------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    sel_next = sel_reg;
    idx_next = idx_reg;
    p0_next = p0_reg;
    p1_next = p1_reg;
    lo_next = lo_reg;
    tx_next = tx_reg;
    unique case (st_reg)
      pipad_pkg::PIPAD_IDLE: begin
        if (start_in) begin
          sel_next = addr_in;
          idx_next = 3'd0;
          st_next = write_in ? pipad_pkg::PIPAD_WRITE
                             : pipad_pkg::PIPAD_READ;
        end
      end
      pipad_pkg::PIPAD_WRITE: begin
        if (byte_in && idx_reg < nbytes) begin
          unique case (sel_reg)
            pipad_pkg::PIPAD_OFS_P0:
              p0_next = put_byte(p0_reg, idx_reg, wdata_in);
            pipad_pkg::PIPAD_OFS_P1:
              p1_next = put_byte(p1_reg, idx_reg, wdata_in);
            pipad_pkg::PIPAD_OFS_TX:
              tx_next = put_byte(tx_reg, idx_reg, wdata_in);
            pipad_pkg::PIPAD_OFS_P2,
            pipad_pkg::PIPAD_OFS_P3,
            pipad_pkg::PIPAD_OFS_P4,
            pipad_pkg::PIPAD_OFS_P5:
              if (idx_reg == 3'd0) begin
                lo_next[sel_reg - pipad_pkg::PIPAD_OFS_P2 + 5'd2] = wdata_in;
              end
            default: ;
          endcase
          idx_next = idx_reg + 3'd1;
        end
        if (stop_in) begin
          st_next = pipad_pkg::PIPAD_IDLE;
        end
      end
      pipad_pkg::PIPAD_READ: begin
        if (byte_in && idx_reg < 3'(pipad_pkg::PIPAD_NBYTES)) begin
          idx_next = idx_reg + 3'd1;
        end
        if (stop_in) begin
          st_next = pipad_pkg::PIPAD_IDLE;
        end
      end
      default: st_next = pipad_pkg::PIPAD_IDLE;
    endcase
  end

  // Read byte at the current position, zero beyond the register width
  always_comb begin
    rdata_next = 8'h00;
    unique case (sel_next)
      pipad_pkg::PIPAD_OFS_P0: rdata_next = get_byte(p0_next, idx_next);
      pipad_pkg::PIPAD_OFS_P1: rdata_next = get_byte(p1_next, idx_next);
      pipad_pkg::PIPAD_OFS_TX: rdata_next = get_byte(tx_next, idx_next);
      pipad_pkg::PIPAD_OFS_P2: rdata_next = lo_byte(lo_next[2], idx_next);
      pipad_pkg::PIPAD_OFS_P3: rdata_next = lo_byte(lo_next[3], idx_next);
      pipad_pkg::PIPAD_OFS_P4: rdata_next = lo_byte(lo_next[4], idx_next);
      pipad_pkg::PIPAD_OFS_P5: rdata_next = lo_byte(lo_next[5], idx_next);
      default: rdata_next = 8'h00;
    endcase
    atx_next = primary_transmitter_role_in ? (tx_next & mask)
                                           : 40'h00_0000_0000;
  end

  // -----------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      st_reg <= pipad_pkg::PIPAD_IDLE;
      sel_reg <= 5'h00;
      idx_reg <= 3'd0;
      p0_reg <= pipad_pkg::PIPAD_RST_P0;
      p1_reg <= pipad_pkg::PIPAD_RST_P1;
      lo_reg[2] <= pipad_pkg::PIPAD_RST_P2;
      lo_reg[3] <= pipad_pkg::PIPAD_RST_P3;
      lo_reg[4] <= pipad_pkg::PIPAD_RST_P4;
      lo_reg[5] <= pipad_pkg::PIPAD_RST_P5;
      tx_reg <= pipad_pkg::PIPAD_RST_TX;
      rdata_reg <= 8'h00;
      atx_reg <= 40'h00_0000_0000;
    end else begin
      st_reg <= st_next;
      sel_reg <= sel_next;
      idx_reg <= idx_next;
      p0_reg <= p0_next;
      p1_reg <= p1_next;
      lo_reg <= lo_next;
      tx_reg <= tx_next;
      rdata_reg <= rdata_next;
      atx_reg <= atx_next;
    end
  end

  assign rdata_out = rdata_reg;
  assign active_tx_out = atx_reg;

  // Pipe 0 uses the transmit address while transmitting, so the
  // acknowledgement matches even if the host left pipe 0 unequal.
  pipad_match u_match (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .check_in(check_in),
    .rx_addr_in(rx_addr_in),
    .mask_in(mask),
    .pipe_en_in(pipe_en_in),
    .p0_in(p0_reg),
    .p1_in(p1_reg),
    .p2_in(lo_reg[2]),
    .p3_in(lo_reg[3]),
    .p4_in(lo_reg[4]),
    .p5_in(lo_reg[5]),
    .tx_in(tx_reg),
    .ptx_in(primary_transmitter_role_in),
    .hit_out(hit_out),
    .pipe_out(pipe_out)
  );

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  chk_p1_first_byte: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    st_reg == pipad_pkg::PIPAD_WRITE && sel_reg == pipad_pkg::PIPAD_OFS_P1
    && byte_in && idx_reg == 3'd0 |=> p1_reg[7:0] == $past(wdata_in))
    else $error("pipe 1 first byte not stored in low byte");
  chk_tx_lsb_first: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    st_reg == pipad_pkg::PIPAD_WRITE && sel_reg == pipad_pkg::PIPAD_OFS_TX
    && byte_in && idx_reg == 3'd1 |=> tx_reg[15:8] == $past(wdata_in))
    else $error("transmit second byte misplaced");
  chk_p0_store: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    st_reg == pipad_pkg::PIPAD_WRITE && sel_reg == pipad_pkg::PIPAD_OFS_P0
    && byte_in && idx_reg == 3'd2 |=> p0_reg[23:16] == $past(wdata_in))
    else $error("pipe 0 third byte misplaced");
  chk_lo_read_p2: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    st_reg == pipad_pkg::PIPAD_READ && sel_reg == pipad_pkg::PIPAD_OFS_P2
    && idx_reg == 3'd0 |-> rdata_out == lo_reg[2])
    else $error("pipe 2 read wrong");
  chk_lo_read_p4: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    st_reg == pipad_pkg::PIPAD_READ && sel_reg == pipad_pkg::PIPAD_OFS_P4
    && idx_reg == 3'd0 |-> rdata_out == lo_reg[4])
    else $error("pipe 4 read wrong");
  chk_tx_role: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    !primary_transmitter_role_in |=> active_tx_out == 40'h00_0000_0000)
    else $error("transmit address shown outside transmitter role");
  chk_hit_pipe2: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    check_in && pipe_en_in == 6'b00_0100 && (((rx_addr_in ^
    {p1_reg[39:8], lo_reg[2]}) & mask) == 40'h00_0000_0000)
    |=> hit_out && pipe_out == 3'd2)
    else $error("pipe 2 match missed");
  chk_no_hit: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    !check_in |=> !hit_out)
    else $error("match flagged without received address");
endmodule

// ### verification/pipad_host.sv
// Host model driving byte-serial register accesses into the address bank.
// Assumes the bank samples on the rising edge; the host moves on the fall.
module pipad_host (
  input wire logic ref_clk_in, // 100 MHz clock
  input wire logic [7:0] rdata_in, // Read byte from bank
  output logic start_out, // Access begins
  output logic write_out, // Access is a write
  output logic [4:0] addr_out, // Register offset
  output logic byte_out, // Byte strobe
  output logic [7:0] wdata_out, // Write byte
  output logic stop_out // Access ends
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    start_out = 1'b0;
    write_out = 1'b0;
    addr_out = 5'h1F;
    byte_out = 1'b0;
    wdata_out = 8'h00;
    stop_out = 1'b0;
  end
  // ---------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------
  task automatic finish_access();
    byte_out = 1'b0;
    wdata_out = ~wdata_out;
    stop_out = 1'b1;
    @(negedge ref_clk_in);
    stop_out = 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input int n,
                    input logic [39:0] d);
    @(negedge ref_clk_in);
    start_out = 1'b1;
    write_out = 1'b1;
    addr_out = a;
    @(negedge ref_clk_in);
    start_out = 1'b0;
    addr_out = ~a;
    // Least significant byte goes first
    for (int k = 0; k < n; k++) begin
      byte_out = 1'b1;
      wdata_out = d[8*k+:8];
      @(negedge ref_clk_in);
    end
    finish_access();
  endtask
  task automatic rd(input logic [4:0] a, input int n,
                    output logic [39:0] d);
    d = 40'h00_0000_0000;
    @(negedge ref_clk_in);
    start_out = 1'b1;
    write_out = 1'b0;
    addr_out = a;
    @(negedge ref_clk_in);
    start_out = 1'b0;
    addr_out = ~a;
    for (int k = 0; k < n; k++) begin
      d[8*k+:8] = rdata_in;
      byte_out = 1'b1;
      @(negedge ref_clk_in);
    end
    finish_access();
  endtask
endmodule

// ### verification/tb.sv
// Self-checking bench for the pipe address register bank.
// Assumes the host model in pipad_host.sv and the bank pipad_regs.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [1:0] aw = 2'h3;
  logic role = 1'b0;
  logic [5:0] pipe_en = 6'h3F;
  logic check = 1'b0;
  logic [39:0] rx_addr = 40'h00_0000_0000;
  logic start, write, byte_stb, stop, hit;
  logic [4:0] addr;
  logic [7:0] wdata, rdata;
  logic [39:0] active_tx, d;
  logic [2:0] pipe;
  int errors = 0;
  int compares = 0;
  always #5 ref_clk_in = ~ref_clk_in;
  pipad_host pipad_host_i (.ref_clk_in(ref_clk_in), .rdata_in(rdata),
    .start_out(start), .write_out(write), .addr_out(addr),
    .byte_out(byte_stb), .wdata_out(wdata), .stop_out(stop));
  pipad_regs pipad_regs_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .start_in(start), .write_in(write), .addr_in(addr),
    .byte_in(byte_stb), .wdata_in(wdata), .stop_in(stop),
    .address_width_setting_in(aw), .primary_transmitter_role_in(role),
    .pipe_en_in(pipe_en), .check_in(check), .rx_addr_in(rx_addr),
    .rdata_out(rdata), .active_tx_out(active_tx), .hit_out(hit),
    .pipe_out(pipe));
  // ---------------------------------------------------------------
  // Checking tasks
  // ---------------------------------------------------------------
  task automatic chk(input string name, input logic [39:0] e,
                     input logic [39:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic rchk(input string name, input logic [4:0] a, input int n,
                      input logic [39:0] e);
    pipad_host_i.rd(a, n, d);
    chk(name, e, d);
  endtask
  task automatic probe(input logic [39:0] a, input logic [2:0] p,
                       input logic h);
    @(negedge ref_clk_in);
    check = 1'b1;
    rx_addr = a;
    @(negedge ref_clk_in);
    check = 1'b0;
    rx_addr = ~a;
    chk("hit", 40'(h), 40'(hit));
    chk("pipe", 40'(p), 40'(pipe));
  endtask
  task automatic test_done();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    errors++;
    test_done();
  end
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(negedge ref_clk_in);
    rst_in = 1'b0;
    rchk("p0", 5'h0A, 5, 40'hE7_E7E7_E7E7);
    rchk("p1", 5'h0B, 5, 40'hC2_C2C2_C2C2);
    rchk("p2", 5'h0C, 1, 40'h00_0000_00C3);
    rchk("p3", 5'h0D, 1, 40'h00_0000_00C4);
    rchk("p4", 5'h0E, 1, 40'h00_0000_00C5);
    rchk("p5", 5'h0F, 1, 40'h00_0000_00C6);
    rchk("tx", 5'h10, 5, 40'hE7_E7E7_E7E7);
    rchk("unmapped", 5'h05, 1, 40'h00_0000_0000);
    chk("active_tx", 40'h00_0000_0000, active_tx);
    $display("test reset values done");
    pipad_host_i.wr(5'h0B, 5, 40'h12_3456_789A);
    rchk("p1", 5'h0B, 5, 40'h12_3456_789A);
    // Pipes 2 to 5 get low bytes 21, 22, 23, 24; second byte is ignored
    for (int i = 0; i < 4; i++) begin
      pipad_host_i.wr(5'(5'h0C + i), 2, 40'(16'hFF21 + i));
      rchk("low_byte", 5'(5'h0C + i), 1, 40'(8'h21 + i));
    end
    pipad_host_i.wr(5'h10, 5, 40'hA1_B2C3_D4E5);
    rchk("tx", 5'h10, 5, 40'hA1_B2C3_D4E5);
    $display("test write readback done");
    @(negedge ref_clk_in);
    aw = 2'h1;
    pipad_host_i.wr(5'h10, 5, 40'h55_6677_8899);
    rchk("tx_3b", 5'h10, 5, 40'hA1_B277_8899);
    pipad_host_i.wr(5'h0B, 5, 40'hFF_FF00_0000);
    rchk("p1_3b", 5'h0B, 5, 40'h12_3400_0000);
    role = 1'b1;
    @(negedge ref_clk_in);
    chk("active_tx", 40'h00_0077_8899, active_tx);
    aw = 2'h2;
    @(negedge ref_clk_in);
    chk("active_tx", 40'h00_B277_8899, active_tx);
    aw = 2'h0;
    @(negedge ref_clk_in);
    chk("active_tx", 40'hA1_B277_8899, active_tx);
    aw = 2'h3;
    @(negedge ref_clk_in);
    chk("active_tx", 40'hA1_B277_8899, active_tx);
    role = 1'b0;
    @(negedge ref_clk_in);
    chk("active_tx", 40'h00_0000_0000, active_tx);
    pipad_host_i.wr(5'h0B, 5, 40'h12_3456_789A);
    $display("test width and role done");
    probe(40'h12_3456_7823, 3'h4, 1'b1);
    probe(40'h12_3456_789A, 3'h1, 1'b1);
    probe(40'h12_3456_7899, 3'h7, 1'b0);
    pipe_en = 6'h2F;
    probe(40'h12_3456_7823, 3'h7, 1'b0);
    pipe_en = 6'h04;
    probe(40'h12_3456_7821, 3'h2, 1'b1);
    pipe_en = 6'h3F;
    $display("test matching done");
    role = 1'b1;
    pipad_host_i.wr(5'h0A, 5, 40'hA1_B277_8899);
    rchk("p0", 5'h0A, 5, 40'hA1_B277_8899);
    probe(40'hA1_B277_8899, 3'h0, 1'b1);
    $display("test acknowledge address done");
    test_done();
  end
endmodule
